// ### acs_pkg.sv
// acs_pkg: constants and types shared by the acs datapath files
// assumes a 32-bit byte-addressed data memory with 16-bit word writes
package acs_pkg;
   localparam int DATA_W       = 40;
   localparam int HALF_W       = 16;
   localparam int EXT_W        = 8;
   localparam int ADDR_W       = 32;
   localparam int NUM_AREGS    = 16;
   localparam int AREG_IDX_W   = 4;
   localparam int LOW_SIGN_BIT = 15;
   localparam int HIGH_SIGN_BIT = 31;
   localparam int HIGH_LSB     = 16;
   localparam int STORE_WORDS  = 4;
   localparam int STRIDE_BYTES = 8;
   localparam int STRIDE_SHIFT = 3;
   localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0002;
   localparam logic [DATA_W-1:0] DREG_RESET = 40'h00_0000_0000;
   localparam logic [ADDR_W-1:0] AREG_RESET = 32'h0000_0000;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam int FLAG0_POS = 0;
   localparam int FLAG1_POS = 1;
   localparam int FLAG2_POS = 2;
   localparam int FLAG3_POS = 3;
   localparam int CTRL_OFFS   = 32'h00;
   localparam int STATUS_OFFS = 32'h04;
   localparam int BASE_OFFS   = 32'h08;
   localparam int STRIDE_OFFS = 32'h0C;
   localparam int AIDX_OFFS   = 32'h10;
   localparam int DREG_OFFS   = 32'h40;

   typedef enum logic [3:0] {
      OP_NONE    = 4'h0,
      OP_CMP_A   = 4'h1,
      OP_CMP_B   = 4'h2,
      OP_STORE_H = 4'h3,
      OP_STORE_L = 4'h4
   } op_t;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_W0    = 6'b000010,
      ST_W1    = 6'b000100,
      ST_W2    = 6'b001000,
      ST_W3    = 6'b010000,
      ST_DONE  = 6'b100000
   } store_state_t;
endpackage

// ### dual_compare_keep_larger.sv
// dual_compare_keep_larger: one signed two-half compare and select
// assumes operands are stable; pure combinational
`timescale 1ns/100ps
module dual_compare_keep_larger
   import acs_pkg::*;
(
   input  wire logic [DATA_W-1:0] src,
   input  wire logic [DATA_W-1:0] dst,
   output logic      [DATA_W-1:0] result,
   output logic                   flag_low,
   output logic                   flag_high
);
   logic src_low_gt;
   logic src_high_gt;

   always_comb
   begin
      // sign from bits 15 and 31 only; extension byte ignored
      src_low_gt  = $signed(src[LOW_SIGN_BIT:0]) > $signed(dst[LOW_SIGN_BIT:0]);
      src_high_gt = $signed(src[HIGH_SIGN_BIT:HIGH_LSB])
                    > $signed(dst[HIGH_SIGN_BIT:HIGH_LSB]);
      result = dst;
      if (src_low_gt)
      begin
         result[LOW_SIGN_BIT:0] = src[LOW_SIGN_BIT:0];
      end
      if (src_high_gt)
      begin
         // extension travels with the high half
         result[DATA_W-1:HIGH_LSB] = src[DATA_W-1:HIGH_LSB];
      end
      flag_low  = ~src_low_gt;
      flag_high = ~src_high_gt;
   end
endmodule // dual_compare_keep_larger

// ### viterbi_acs_select_datapath.sv
// viterbi_acs_select_datapath: compare/select flags, survivor stores, avalon slave
// assumes one memory write port with a ready handshake; software loads registers
`timescale 1ns/100ps
module viterbi_acs_select_datapath
   import acs_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic [7:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   output logic                    mem_write,
   output logic      [ADDR_W-1:0]  mem_address,
   output logic      [HALF_W-1:0]  mem_writedata,
   input  wire logic               mem_ready
);
   // data registers d0..d15, 40 bits each
   logic [DATA_W-1:0]     dreg_q [16];
   logic [ADDR_W-1:0]     areg_q [NUM_AREGS];
   logic [ADDR_W-1:0]     stride_q;
   logic [3:0]            flags_q;
   logic                  big_endian_q;
   logic                  upper_bank_q;
   logic [AREG_IDX_W-1:0] aidx_q;
   store_state_t          state_q;
   op_t                   op_q;
   logic [ADDR_W-1:0]     base_q;
   logic [HALF_W-1:0]     word_q [STORE_WORDS];
   logic                  busy_q;
   logic                  ack_q;

   // register indices for the two banks
   logic [3:0] pa_src, pa_dst, pb_src, pb_dst, sa, sb;
   always_comb
   begin
      pa_src = upper_bank_q ? 4'hC : 4'h4;
      pa_dst = upper_bank_q ? 4'hA : 4'h2;
      pb_src = upper_bank_q ? 4'h8 : 4'h0;
      pb_dst = upper_bank_q ? 4'hE : 4'h6;
      sa     = upper_bank_q ? 4'h9 : 4'h1;
      sb     = upper_bank_q ? 4'hB : 4'h3;
   end

   logic [DATA_W-1:0] cmp_a_res, cmp_b_res;
   logic cmp_a_fl, cmp_a_fh, cmp_b_fl, cmp_b_fh;

   dual_compare_keep_larger u_cmp_a (
      .src       (dreg_q[pa_src]),
      .dst       (dreg_q[pa_dst]),
      .result    (cmp_a_res),
      .flag_low  (cmp_a_fl),
      .flag_high (cmp_a_fh)
   );

   dual_compare_keep_larger u_cmp_b (
      .src       (dreg_q[pb_src]),
      .dst       (dreg_q[pb_dst]),
      .result    (cmp_b_res),
      .flag_low  (cmp_b_fl),
      .flag_high (cmp_b_fh)
   );

   // shift one left, insert bit at lsb of the half (bit 0 of the stored word for either half)
   function automatic logic [HALF_W-1:0] shift_in(input logic [HALF_W-1:0] v,
                                                    input logic b);
      shift_in = {v[HALF_W-2:0], b};
   endfunction

   function automatic logic [HALF_W-1:0] half_of(input logic [DATA_W-1:0] v,
                                                   input logic hi);
      half_of = hi ? v[HIGH_SIGN_BIT:HIGH_LSB] : v[LOW_SIGN_BIT:0];
   endfunction

   // byte offset of word position under endian mode
   function automatic logic [ADDR_W-1:0] pos_offset(input logic [1:0] pos,
                                                      input logic be);
      logic [1:0] slot;
      slot = be ? (pos ^ 2'b01) : pos;
      pos_offset = ADDR_W'(slot) * WORD_STEP;
   endfunction

   // avalon decode
   logic        acc;
   logic [7:0]  offs;
   logic        is_ctrl, is_status, is_base, is_stride, is_aidx, is_dreg;
   logic [3:0]  dsel;
   logic        dsel_ext;
   always_comb
   begin
      acc       = (avs_read | avs_write) & ~ack_q;
      offs      = avs_address;
      is_ctrl   = offs == 8'(CTRL_OFFS);
      is_status = offs == 8'(STATUS_OFFS);
      is_base   = offs == 8'(BASE_OFFS);
      is_stride = offs == 8'(STRIDE_OFFS);
      is_aidx   = offs == 8'(AIDX_OFFS);
      is_dreg   = offs >= 8'(DREG_OFFS) && offs < 8'(DREG_OFFS + 128);
      // base offset sets bit 6; flip it so 0x40 maps to register zero
      dsel      = offs[6:3] ^ 4'h8;
      dsel_ext  = offs[2];
   end

   // ctrl write starts an op; refused (held in wait) while busy
   logic start;
   assign start = acc & avs_write & is_ctrl & ~busy_q;

   // waitrequest low for one cycle per access; ctrl write waits for idle
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= acc & ~(avs_write & is_ctrl & busy_q);
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         avs_waitrequest <= ~(acc & ~(avs_write & is_ctrl & busy_q));
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         avs_readdata <= 32'h0000_0000;
      end
      else if (acc & avs_read)
      begin
         if (is_status)
            avs_readdata <= {27'h0, busy_q, flags_q};
         else if (is_ctrl)
            avs_readdata <= {24'h0, aidx_q, 2'b00, upper_bank_q, big_endian_q};
         else if (is_base)
            avs_readdata <= areg_q[aidx_q];
         else if (is_stride)
            avs_readdata <= stride_q;
         else if (is_aidx)
            avs_readdata <= {28'h0, aidx_q};
         else if (is_dreg)
            avs_readdata <= dsel_ext ? {24'h0, dreg_q[dsel][DATA_W-1:32]}
                                     : dreg_q[dsel][31:0];
         else
            avs_readdata <= 32'h0000_0000;
      end
   end

   // control fields: endian, bank, base index, opcode in [11:8]
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         big_endian_q <= 1'b0;
         upper_bank_q <= 1'b0;
         aidx_q       <= '0;
         op_q         <= OP_NONE;
      end
      else if (start & avs_byteenable[0])
      begin
         big_endian_q <= avs_writedata[0];
         upper_bank_q <= avs_writedata[1];
         aidx_q       <= avs_writedata[7:4];
         op_q         <= op_t'(avs_writedata[11:8]);
      end
      // index frozen while busy, else the post-increment hits another register
      else if (acc & avs_write & is_aidx & ~busy_q)
      begin
         aidx_q <= avs_writedata[3:0];
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         stride_q <= AREG_RESET;
      else if (acc & avs_write & is_stride)
         stride_q <= avs_writedata;
   end

   // compare runs in the cycle after the ctrl write; stores never touch data
   logic do_cmp_a, do_cmp_b;
   assign do_cmp_a = state_q == ST_DONE && op_q == OP_CMP_A;
   assign do_cmp_b = state_q == ST_DONE && op_q == OP_CMP_B;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 16; i++)
            dreg_q[i] <= DREG_RESET;
      end
      else if (do_cmp_a)
      begin
         dreg_q[pa_dst] <= cmp_a_res;
      end
      else if (do_cmp_b)
      begin
         dreg_q[pb_dst] <= cmp_b_res;
      end
      else if (acc & avs_write & is_dreg & ~busy_q)
      begin
         // only software writes here; stores read only
         if (dsel_ext)
            dreg_q[dsel][DATA_W-1:32] <= avs_writedata[EXT_W-1:0];
         else
            dreg_q[dsel][31:0] <= avs_writedata;
      end
   end

   // flags change only on a compare, held otherwise
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         flags_q <= FLAGS_RESET;
      else if (do_cmp_a)
      begin
         flags_q[FLAG0_POS] <= cmp_a_fl;
         flags_q[FLAG1_POS] <= cmp_a_fh;
      end
      else if (do_cmp_b)
      begin
         flags_q[FLAG2_POS] <= cmp_b_fl;
         flags_q[FLAG3_POS] <= cmp_b_fh;
      end
   end

   // store sequencer
   logic store_op;
   logic hi_op;
   assign store_op = op_q == OP_STORE_H || op_q == OP_STORE_L;
   assign hi_op    = op_q == OP_STORE_H;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         busy_q  <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (start)
               begin
                  state_q <= ST_DONE;
                  busy_q  <= 1'b1;
               end
            end
            ST_DONE:
            begin
               if (store_op)
                  state_q <= ST_W0;
               else
               begin
                  state_q <= ST_IDLE;
                  busy_q  <= 1'b0;
               end
            end
            ST_W0: if (mem_ready) state_q <= ST_W1;
            ST_W1: if (mem_ready) state_q <= ST_W2;
            ST_W2: if (mem_ready) state_q <= ST_W3;
            ST_W3:
            begin
               if (mem_ready)
               begin
                  state_q <= ST_IDLE;
                  busy_q  <= 1'b0;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

   // snapshot of the four words and the base at store start
   logic sel2, sel3;
   always_comb
   begin
      sel2 = hi_op ? flags_q[FLAG1_POS] : flags_q[FLAG0_POS];
      sel3 = hi_op ? flags_q[FLAG3_POS] : flags_q[FLAG2_POS];
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < STORE_WORDS; i++)
            word_q[i] <= '0;
         base_q <= AREG_RESET;
      end
      else if (state_q == ST_DONE && store_op)
      begin
         word_q[0] <= half_of(dreg_q[pa_dst], hi_op);
         word_q[1] <= half_of(dreg_q[pb_dst], hi_op);
         word_q[2] <= shift_in(half_of(sel2 ? dreg_q[sb] : dreg_q[sa], hi_op),
                               1'b0);
         word_q[3] <= shift_in(half_of(sel3 ? dreg_q[sb] : dreg_q[sa], hi_op),
                               1'b1);
         base_q <= areg_q[aidx_q];
      end
   end

   // address registers: software write or post-increment
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_AREGS; i++)
            areg_q[i] <= AREG_RESET;
      end
      else if (state_q == ST_W3 && mem_ready)
      begin
         areg_q[aidx_q] <= base_q + (stride_q << STRIDE_SHIFT);
      end
      else if (acc & avs_write & is_base & ~busy_q)
      begin
         areg_q[aidx_q] <= avs_writedata;
      end
   end

   // memory port, registered; next word presented after each accepted one
   logic [1:0] next_pos;
   logic       next_valid;
   always_comb
   begin
      next_pos   = 2'd0;
      next_valid = 1'b0;
      case (state_q)
         ST_DONE: begin next_pos = 2'd0; next_valid = store_op; end
         ST_W0:   begin next_pos = mem_ready ? 2'd1 : 2'd0; next_valid = 1'b1; end
         ST_W1:   begin next_pos = mem_ready ? 2'd2 : 2'd1; next_valid = 1'b1; end
         ST_W2:   begin next_pos = mem_ready ? 2'd3 : 2'd2; next_valid = 1'b1; end
         ST_W3:   begin next_pos = 2'd3; next_valid = ~mem_ready; end
         default: begin next_pos = 2'd0; next_valid = 1'b0; end
      endcase
   end

   logic [ADDR_W-1:0] cur_base;
   logic [HALF_W-1:0] cur_word;
   always_comb
   begin
      cur_base = (state_q == ST_DONE) ? areg_q[aidx_q] : base_q;
      cur_word = word_q[next_pos];
      if (state_q == ST_DONE)
      begin
         cur_word = half_of(dreg_q[pa_dst], hi_op);
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         mem_write     <= 1'b0;
         mem_address   <= AREG_RESET;
         mem_writedata <= '0;
      end
      else
      begin
         mem_write     <= next_valid;
         mem_address   <= cur_base + pos_offset(next_pos, big_endian_q);
         mem_writedata <= cur_word;
      end
   end
endmodule // viterbi_acs_select_datapath

// ### acs_properties.sv
// acs_properties: port checks for the acs datapath
// assumes bind to viterbi_acs_select_datapath, one clock, async rst
`timescale 1ns/100ps
module acs_properties
   import acs_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              mem_write,
   input wire logic [ADDR_W-1:0] mem_address,
   input wire logic [HALF_W-1:0] mem_writedata,
   input wire logic              mem_ready
);
   logic [1:0] wcnt_q;
   // word position in a group; every store sends exactly four
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         wcnt_q <= 2'h0;
      else if (mem_write && mem_ready)
         wcnt_q <= wcnt_q + 2'h1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_word0_done;
      mem_write && mem_ready && wcnt_q == 2'h0;
   endsequence
   sequence s_next_word;
      !mem_write || mem_address - $past(mem_address) == 32'h2
         || $past(mem_address) - mem_address == 32'h2;
   endsequence
   property p_word_step;
      s_word0_done |=> s_next_word;
   endproperty
   a_word_step: assert property (p_word_step)
      else $error("word one not next to word zero");
   property p_mem_hold;
      mem_write && !mem_ready |=> mem_write && $stable(mem_address) && $stable(mem_writedata);
   endproperty
   a_mem_hold: assert property (p_mem_hold)
      else $error("stalled word changed");
   property p_word2;
      mem_write && wcnt_q == 2'h2 |-> !mem_writedata[0];
   endproperty
   a_word2: assert property (p_word2)
      else $error("word two inserted bit not zero");
   property p_word3;
      mem_write && wcnt_q == 2'h3 |-> mem_writedata[0];
   endproperty
   a_word3: assert property (p_word3)
      else $error("word three inserted bit not one");
   property p_read_answer;
      avs_read && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read not answered");
   property p_wait_pulse;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse)
      else $error("acknowledge longer than one cycle");
   property p_ack_cause;
      $fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("acknowledge without request");
   property p_rdata_hold;
      $changed(avs_readdata) |-> $past(avs_read);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without read");
endmodule // acs_properties

// ### acs_mem_model.sv
// acs_mem_model: data memory side of the survivor stores
// assumes a word is taken at an edge with write and ready high
`timescale 1ns/100ps
module acs_mem_model
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic slow,
   output logic      mem_ready
);
   logic [1:0] cnt_q;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         cnt_q <= 2'h0;
      else
         cnt_q <= cnt_q + 2'h1;
   end
   // slow: ready one cycle in four, so words must wait
   assign mem_ready = !slow || cnt_q == 2'h3;
endmodule // acs_mem_model

// ### tb_viterbi_acs_select_datapath.sv
// tb_viterbi_acs_select_datapath: self-checking bench with memory model
// assumes acs_pkg, design, checker and memory model compiled first
`timescale 1ns/100ps
module tb_viterbi_acs_select_datapath;
   import acs_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, mem_address, base, st;
   logic        avs_waitrequest, mem_write, mem_ready, lo_gt, hi_gt, bank, be;
   logic        slow = 1'b0;
   logic [15:0] mem_writedata, t;
   logic [15:0] w[4];
   logic [31:0] rd_q[$];
   logic [47:0] wr_q[$];
   logic [39:0] dr[16];
   logic [3:0]  ef;
   int          i, s, d, p, k, hs;
   int          err_count = 0;
   int          tests_run = 0;
   always #4 clock = ~clock;
   viterbi_acs_select_datapath i_dut (.clock, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_write,
      .mem_address, .mem_writedata, .mem_ready);
   acs_mem_model i_mem (.clock, .rst, .slow, .mem_ready);
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
      int n;
      avs_address <= a;
      avs_writedata <= dt;
      avs_read <= !w;
      avs_write <= w;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 200);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 200)
      begin
         err_count++;
         report_and_stop();
      end
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wreg(input int n);
      bus(1'b1, 8'(DREG_OFFS + 8 * n), dr[n][31:0]);
      bus(1'b1, 8'(DREG_OFFS + 8 * n + 4), {24'h0, dr[n][39:32]});
   endtask
   // start an op, then poll busy; stores may stall on memory
   task automatic run_op(input logic [3:0] op);
      int n;
      bus(1'b1, 8'(CTRL_OFFS), {20'h0, op, i[3:0], 2'b0, bank, be});
      n = 0;
      do
      begin
         bus(1'b0, 8'(STATUS_OFFS), 32'h0);
         n++;
      end while (avs_readdata[4] !== 1'b0 && n < 100);
      if (n >= 100)
      begin
         err_count++;
         report_and_stop();
      end
   endtask
   always @(posedge clock)
   begin
      if (avs_read && !avs_waitrequest && rd_q.size() > 0)
         chk({16'h0, avs_readdata}, {16'h0, rd_q.pop_front()});
      if (mem_write && mem_ready)
         chk({mem_address, mem_writedata}, wr_q.size() > 0 ? wr_q.pop_front() : 'x);
   end
   initial
   begin
      void'($urandom(32'hEFA7));
      ef = 4'h0;
      foreach (dr[n])
         dr[n] = 40'h0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(8'(STATUS_OFFS), 32'h0);
      rd(8'hFC, 32'h0);
      for (i = 0; i < 16; i++)
      begin
         bank = i[2];
         be = i[3];
         s = bank * 8 + (i[0] ? 0 : 4);
         d = bank * 8 + (i[0] ? 6 : 2);
         dr[s] = 40'({$urandom, $urandom});
         dr[d] = 40'({$urandom, $urandom});
         // equal halves, extension bytes still differ
         if (i % 4 == 0)
            dr[d][31:0] = dr[s][31:0];
         wreg(s);
         wreg(d);
         lo_gt = $signed(dr[s][15:0]) > $signed(dr[d][15:0]);
         hi_gt = $signed(dr[s][31:16]) > $signed(dr[d][31:16]);
         if (lo_gt)
            dr[d][15:0] = dr[s][15:0];
         if (hi_gt)
            dr[d][39:16] = dr[s][39:16];
         ef[i[0] ? 2 : 0] = !lo_gt;
         ef[i[0] ? 3 : 1] = !hi_gt;
         run_op(i[0] ? 4'h2 : 4'h1);
         rd(8'(STATUS_OFFS), {28'h0, ef});
         rd(8'(DREG_OFFS + 8 * d), dr[d][31:0]);
         rd(8'(DREG_OFFS + 8 * d + 4), {24'h0, dr[d][39:32]});
         p = bank * 8;
         for (k = 1; k < 4; k += 2)
         begin
            dr[p + k] = 40'({$urandom, $urandom});
            wreg(p + k);
         end
         hs = i[1] ? 16 : 0;
         base = $urandom & 32'hFFFF_FFFE;
         st = $urandom_range(255);
         w[0] = 16'(dr[p + 2] >> hs);
         w[1] = 16'(dr[p + 6] >> hs);
         t = 16'(dr[ef[i[1] ? 1 : 0] ? p + 3 : p + 1] >> hs);
         w[2] = {t[14:0], 1'b0};
         t = 16'(dr[ef[i[1] ? 3 : 2] ? p + 3 : p + 1] >> hs);
         w[3] = {t[14:0], 1'b1};
         for (k = 0; k < 4; k++)
            wr_q.push_back({base + 32'((2 * k) ^ (be ? 2 : 0)), w[k]});
         bus(1'b1, 8'(AIDX_OFFS), {28'h0, i[3:0]});
         bus(1'b1, 8'(BASE_OFFS), base);
         bus(1'b1, 8'(STRIDE_OFFS), st);
         slow <= 1'($urandom);
         run_op(i[1] ? 4'h3 : 4'h4);
         rd(8'(BASE_OFFS), base + st * 8);
         rd(8'(DREG_OFFS + 8 * (p + 1)), dr[p + 1][31:0]);
      end
      // no-op leaves flags alone; control fields read back
      run_op(4'h0);
      rd(8'(STATUS_OFFS), {28'h0, ef});
      rd(8'(CTRL_OFFS), 32'h0000_0003);
      rd(8'(STRIDE_OFFS), st);
      rd(8'(AIDX_OFFS), 32'h0000_0000);
      repeat (2) @(posedge clock);
      chk(48'(rd_q.size() + wr_q.size()), 48'h0);
      report_and_stop();
   end
endmodule // tb_viterbi_acs_select_datapath
bind viterbi_acs_select_datapath acs_properties i_props (.clock, .rst, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .mem_write, .mem_address, .mem_writedata, .mem_ready);
